// [inc/swps_pkg.sv]
// Constants for the sleep and wake power sequencer: register map, field
// positions, reset values and sequencer states.
// Assumes 32-bit register accesses at byte offsets on an 8-bit address.
`default_nettype none
package swps_pkg;

    // ========================================================================
    // Register offsets
    localparam logic [7:0] SWPS_OFS_GEN_CTRL    = 8'h00;
    localparam logic [7:0] SWPS_OFS_WAKE_LOW    = 8'h04;
    localparam logic [7:0] SWPS_OFS_WAKE_HIGH   = 8'h08;
    localparam logic [7:0] SWPS_OFS_DORMANT_SET = 8'h0c;
    localparam logic [7:0] SWPS_OFS_RAMP1_SET   = 8'h10;
    localparam logic [7:0] SWPS_OFS_RAMP2_SET   = 8'h14;

    // ========================================================================
    // General control fields
    localparam int SWPS_GC_SLEEP_REQ = 1;
    localparam int SWPS_GC_PIN_EN    = 2;
    localparam int SWPS_GC_PIN_LEVEL = 3;
    localparam int SWPS_GC_TIMER_EN  = 4;
    localparam int SWPS_GC_WIDE_CMP  = 5;
    localparam logic [31:0] SWPS_GC_RW_MASK = 32'h0000_003c;
    localparam logic [31:0] SWPS_GC_RESET   = 32'h0000_0008;

    // ========================================================================
    // Per-state settings fields
    localparam int SWPS_SET_CORE_EN  = 0;
    localparam int SWPS_SET_ANA_EN   = 1;
    localparam int SWPS_SET_PLL_EN   = 4;
    localparam int SWPS_SET_IO_EN    = 5;
    localparam int SWPS_SET_CORE_PFM = 8;
    localparam int SWPS_SET_ANA_PFM  = 9;
    localparam int SWPS_SET_CLK_STOP = 14;
    localparam int SWPS_SET_DWELL_LO = 16;
    localparam int SWPS_DWELL_W      = 5;
    localparam logic [31:0] SWPS_SET_RW_MASK = 32'h001f_4331;
    // Read-only analogue enable per state
    localparam logic [31:0] SWPS_DORMANT_RO = 32'h0000_0000;
    localparam logic [31:0] SWPS_RAMP1_RO   = 32'h0000_0000;
    localparam logic [31:0] SWPS_RAMP2_RO   = 32'h0000_0002;
    // Writable-field reset values (dwell 16 in every state)
    localparam logic [31:0] SWPS_DORMANT_RESET = 32'h0010_0000;
    localparam logic [31:0] SWPS_RAMP1_RESET   = 32'h0010_0020;
    localparam logic [31:0] SWPS_RAMP2_RESET   = 32'h0010_0031;
    // Supplies while running: everything on, tile clock running
    localparam logic [31:0] SWPS_RUNNING_SET   = 32'h0000_0033;

    // ========================================================================
    // Sequencer states
    typedef enum logic [1:0]
    {
        SWPS_RUNNING = 2'b00,
        SWPS_DORMANT = 2'b01,
        SWPS_RAMP1   = 2'b10,
        SWPS_RAMP2   = 2'b11
    } swps_state_type;

endpackage : swps_pkg

`default_nettype wire

// [rtl/swps_top.sv]
// Sleep and wake power sequencer: wake-time registers, per-state supply
// settings, dwell counting and the dormant / ramp-up / running walk.
// Assumes a simple 32-bit register port, a free 64-bit real-time counter
// input, and a tick input marking each edge of the currently enabled clock.
//
// What this block does
// - Low wake-time word, read-write, reset zero, used only dormant with timer wake.
// - High wake-time word, reset zero, ignored unless wide comparison enabled.
// - Each settings register drives outputs only while in its own state.
// - Dwell field n gives minimum stay of 2 to the n cycles, resets 16.
// - Dormant leaves after dwell when timer or pin wake condition holds.
// - Dwell count advances on each tick of the currently enabled clock.
// - Ramp-up states leave after dwell only when all enabled supplies good.
// - Bit 14 stops the tile clock during its state, resets 0.
// - Bits 8 and 9 pick core and analogue modulation, 1 is PFM.
// - Bit 5 enables IO supply; resets 0 dormant, 1 in ramp-ups.
// - Bit 4 enables PLL regulator; resets 1 only in second ramp-up.
// - Bit 0 enables core converter; resets 1 only in second ramp-up.
// - Bit 1 analogue enable is read-only: 0, 0, 1 per state.
// - General control bit 4 enables timer wake, resets 0.
// - General control bit 5 selects 64-bit comparison, resets 0.
// - Bit 2 enables pin wake; bit 3 picks its level, default high.
// - Writing 1 to self-clearing bit 1 while running starts sleep.
`timescale 1ns/100ps
`default_nettype none

module swps_top
    import swps_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    input  wire logic        dwell_tick,
    input  wire logic [63:0] rtc_count,
    input  wire logic        wake_pin,
    input  wire logic        core_good,
    input  wire logic        ana_good,
    input  wire logic        pll_good,
    input  wire logic        io_good,
    output logic             core_conv_en,
    output logic             ana_conv_en,
    output logic             pll_reg_en,
    output logic             io_out_en,
    output logic             core_pfm,
    output logic             ana_pfm,
    output logic             tile_clk_stop,
    output logic      [1:0]  seq_state
);

    // ========================================================================
    // Registers
    logic [31:0]    gen_ctrl_r;
    logic [31:0]    wake_low_r;
    logic [31:0]    wake_high_r;
    logic [31:0]    set_r [3];
    swps_state_type state_r;
    swps_state_type state_nxt;
    logic [31:0]    dwell_cnt_r;
    logic [31:0]    outs_r;

    // Minimum-stay threshold: count reaches 2^n - 1 after 2^n - 1 ticks
    function automatic logic [31:0] swps_dwell_last(input logic [31:0] settings);
        logic [4:0] n;
        n = settings[SWPS_SET_DWELL_LO +: SWPS_DWELL_W];
        swps_dwell_last = (32'h0000_0001 << n) - 32'h0000_0001;
    endfunction : swps_dwell_last

    // ========================================================================
    // Address decode
    wire wr_gen   = reg_wr && (reg_addr == SWPS_OFS_GEN_CTRL);
    wire wr_low   = reg_wr && (reg_addr == SWPS_OFS_WAKE_LOW);
    wire wr_high  = reg_wr && (reg_addr == SWPS_OFS_WAKE_HIGH);
    wire wr_dorm  = reg_wr && (reg_addr == SWPS_OFS_DORMANT_SET);
    wire wr_ramp1 = reg_wr && (reg_addr == SWPS_OFS_RAMP1_SET);
    wire wr_ramp2 = reg_wr && (reg_addr == SWPS_OFS_RAMP2_SET);

    // Sleep request is honoured only while running; otherwise dropped
    wire sleep_go = wr_gen && reg_wdata[SWPS_GC_SLEEP_REQ]
                    && (state_r == SWPS_RUNNING);

    // Read-only analogue bit is merged at read time, never stored
    wire [31:0] dorm_view  = set_r[0] | SWPS_DORMANT_RO;
    wire [31:0] ramp1_view = set_r[1] | SWPS_RAMP1_RO;
    wire [31:0] ramp2_view = set_r[2] | SWPS_RAMP2_RO;

    // ========================================================================
    // Wake conditions
    wire [63:0] wake_time = {wake_high_r, wake_low_r};
    wire        wide_cmp  = gen_ctrl_r[SWPS_GC_WIDE_CMP];
    wire        rtc_hit   = wide_cmp ? (rtc_count >= wake_time)
                                     : (rtc_count[31:0] >= wake_low_r);
    wire        timer_wake = gen_ctrl_r[SWPS_GC_TIMER_EN] && rtc_hit;
    wire        pin_wake   = gen_ctrl_r[SWPS_GC_PIN_EN]
                             && (wake_pin == gen_ctrl_r[SWPS_GC_PIN_LEVEL]);

    // ========================================================================
    // Settings of the state now occupied
    wire [31:0] cur_set = (state_r == SWPS_DORMANT) ? dorm_view  :
                          (state_r == SWPS_RAMP1)   ? ramp1_view :
                          (state_r == SWPS_RAMP2)   ? ramp2_view :
                                                      SWPS_RUNNING_SET;

    wire dwell_done = (dwell_cnt_r >= swps_dwell_last(cur_set));

    // Every enabled supply must report good; disabled ones are don't-care
    wire supplies_good = (!cur_set[SWPS_SET_CORE_EN] || core_good)
                      && (!cur_set[SWPS_SET_ANA_EN]  || ana_good)
                      && (!cur_set[SWPS_SET_PLL_EN]  || pll_good)
                      && (!cur_set[SWPS_SET_IO_EN]   || io_good);

    // Dwell is sampled only on a tick, so a slow clock stretches the stay
    wire step_ok = dwell_tick && dwell_done;

    // ========================================================================
    // Next state
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            SWPS_RUNNING:
                if (sleep_go)
                    state_nxt = SWPS_DORMANT;
            SWPS_DORMANT:
                if (step_ok && (timer_wake || pin_wake))
                    state_nxt = SWPS_RAMP1;
            SWPS_RAMP1:
                if (step_ok && supplies_good)
                    state_nxt = SWPS_RAMP2;
            SWPS_RAMP2:
                if (step_ok && supplies_good)
                    state_nxt = SWPS_RUNNING;
        endcase
    end

    // State and dwell counter; counter restarts on every state change
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r     <= SWPS_RUNNING;
            dwell_cnt_r <= 32'h0000_0000;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_nxt != state_r)
                dwell_cnt_r <= 32'h0000_0000;
            else if (dwell_tick && !dwell_done)
                dwell_cnt_r <= dwell_cnt_r + 32'h0000_0001;
        end
    end

    // ========================================================================
    // Register writes; sleep request bit is never stored (self-clearing)
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gen_ctrl_r  <= SWPS_GC_RESET;
            wake_low_r  <= 32'h0000_0000;
            wake_high_r <= 32'h0000_0000;
            set_r[0]    <= SWPS_DORMANT_RESET;
            set_r[1]    <= SWPS_RAMP1_RESET;
            set_r[2]    <= SWPS_RAMP2_RESET;
        end
        else
        begin
            if (wr_gen)
                gen_ctrl_r <= reg_wdata & SWPS_GC_RW_MASK;
            if (wr_low)
                wake_low_r <= reg_wdata;
            if (wr_high)
                wake_high_r <= reg_wdata;
            if (wr_dorm)
                set_r[0] <= reg_wdata & SWPS_SET_RW_MASK;
            if (wr_ramp1)
                set_r[1] <= reg_wdata & SWPS_SET_RW_MASK;
            if (wr_ramp2)
                set_r[2] <= reg_wdata & SWPS_SET_RW_MASK;
        end
    end

    // ========================================================================
    // Read data, one cycle after the read strobe; unmapped reads as zero
    wire [31:0] rd_mux = (reg_addr == SWPS_OFS_GEN_CTRL)    ? gen_ctrl_r  :
                         (reg_addr == SWPS_OFS_WAKE_LOW)    ? wake_low_r  :
                         (reg_addr == SWPS_OFS_WAKE_HIGH)   ? wake_high_r :
                         (reg_addr == SWPS_OFS_DORMANT_SET) ? dorm_view   :
                         (reg_addr == SWPS_OFS_RAMP1_SET)   ? ramp1_view  :
                         (reg_addr == SWPS_OFS_RAMP2_SET)   ? ramp2_view  :
                                                              32'h0000_0000;

    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata <= rd_mux;
    end

    // ========================================================================
    // Supply outputs registered so regulators see glitch-free enables
    always_ff @(posedge clk)
    begin
        if (rst)
            outs_r <= SWPS_RUNNING_SET;
        else
            outs_r <= cur_set;
    end

    assign core_conv_en  = outs_r[SWPS_SET_CORE_EN];
    assign ana_conv_en   = outs_r[SWPS_SET_ANA_EN];
    assign pll_reg_en    = outs_r[SWPS_SET_PLL_EN];
    assign io_out_en     = outs_r[SWPS_SET_IO_EN];
    assign core_pfm      = outs_r[SWPS_SET_CORE_PFM];
    assign ana_pfm       = outs_r[SWPS_SET_ANA_PFM];
    assign tile_clk_stop = outs_r[SWPS_SET_CLK_STOP];
    assign seq_state     = state_r;

endmodule : swps_top

`default_nettype wire

// [verification/swps_supply_model.sv]
// Behavioural supply regulators beside the power sequencer.
// Assumes the sequencer's clk and rst; lag sets how slowly supplies settle.
`timescale 1ns/100ps
`default_nettype none
module swps_supply_model
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] en,
    input  wire logic [3:0] lag,
    output logic      [3:0] good
);
    // ========================================================================
    // Settling counter
    logic [3:0] en_r;
    logic [3:0] cnt_r;
    // Any enable change restarts settling for all: harsh, but a real rail can dip
    always_ff @(posedge clk)
    begin
        en_r  <= en;
        cnt_r <= (rst || en != en_r) ? 4'h0 : ((cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1);
    end
    // Report only enables already seen by the settling counter, so a fresh enable
    // can never read good before its restart has been counted
    assign good = (cnt_r >= lag) ? en_r : 4'h0;
endmodule : swps_supply_model
`default_nettype wire

// [verification/swps_top_chk.sv]
// Assertion checker on the power sequencer's top ports.
// Assumes one clock domain; bound to swps_top at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module swps_top_chk
    import swps_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        dwell_tick,
    input wire logic        core_conv_en,
    input wire logic        tile_clk_stop,
    input wire logic [1:0]  seq_state
);
    // ========================================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Steps of a register access and of a sleep request
    sequence s_sleep;
        reg_wr && reg_addr == SWPS_OFS_GEN_CTRL && reg_wdata[SWPS_GC_SLEEP_REQ];
    endsequence
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    a_state_order: assert property ($changed(seq_state) |-> seq_state == $past(seq_state) + 2'h1)
        else $error("state step out of order");
    a_sleep_entry: assert property (seq_state == SWPS_RUNNING ##0 s_sleep |=> seq_state == SWPS_DORMANT)
        else $error("sleep request not taken");
    a_stay_run: assert property (seq_state == SWPS_RUNNING && !reg_wr |=> seq_state == SWPS_RUNNING)
        else $error("left running without request");
    a_tick_gate: assert property (seq_state != SWPS_RUNNING && !dwell_tick |=> $stable(seq_state))
        else $error("state moved without tick");
    a_run_outputs: assert property ((seq_state == SWPS_RUNNING) [*2] |-> core_conv_en && !tile_clk_stop)
        else $error("running outputs wrong");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_ana_ro_high: assert property (s_rd(SWPS_OFS_RAMP2_SET) |=> reg_rdata[SWPS_SET_ANA_EN])
        else $error("analogue enable bit wrong");
    a_gc_bits: assert property (s_rd(SWPS_OFS_GEN_CTRL) |=> (reg_rdata & ~SWPS_GC_RW_MASK) == 32'h0)
        else $error("control read shows unstored bits");
endmodule : swps_top_chk
bind swps_top swps_top_chk chk (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .dwell_tick(dwell_tick), .core_conv_en(core_conv_en), .tile_clk_stop(tile_clk_stop),
    .seq_state(seq_state));
`default_nettype wire

// [verification/tb_swps_top.sv]
// Testbench for the power sequencer: register resets and masks, then sleep
// and wake walks on pin and timer. Assumes the supply model on the enables.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %0h want %0h", $time, (a), (e)); end end
module tb_swps_top
    import swps_pkg::*;
;
    // ========================================================================
    // Signals and instances
    logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tick = 1'b1, pin = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [63:0] rtc = 64'h5_0000_2000;
    logic [3:0]  lag = 4'h8, good;
    wire logic [6:0] outs;
    logic [1:0]  st;
    int          n_fail = 0, compares = 0, c;
    logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] rv [7] = '{32'h8, 32'h0, 32'h0, 32'h0010_0000, 32'h0010_0020, 32'h0010_0033, 32'h0};
    swps_top dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .dwell_tick(tick), .rtc_count(rtc),
        .wake_pin(pin), .core_good(good[3]), .ana_good(good[2]), .pll_good(good[1]),
        .io_good(good[0]), .core_conv_en(outs[6]), .ana_conv_en(outs[5]),
        .pll_reg_en(outs[4]), .io_out_en(outs[3]), .core_pfm(outs[2]), .ana_pfm(outs[1]),
        .tile_clk_stop(outs[0]), .seq_state(st));
    swps_supply_model sup (.clk(clk), .rst(rst), .en(outs[6:3]), .lag(lag), .good(good));
    // Strobes rise after one edge and drop after the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        {reg_rd, addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        `CHK(rdata, e)
    endtask : rd
    // Bounded wait, so a stuck sequencer shows up as a mismatch
    task automatic wait_st(input logic [1:0] s, output int n);
        n = 0;
        while (st !== s && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) `CHK(st, s)
    endtask : wait_st
    // One sleep and wake walk, held dormant until pin or counter moves
    task automatic walk(input logic [31:0] gc, input logic pin_w, input logic [63:0] rtc_w);
        wr(SWPS_OFS_GEN_CTRL, gc | 32'h2);
        wait_st(SWPS_DORMANT, c);
        repeat (12) @(posedge clk);
        `CHK(st, SWPS_DORMANT)
        `CHK(outs, 7'b0001111)
        {tick, pin, rtc} <= {1'b0, pin_w, rtc_w};
        repeat (20) @(posedge clk);
        `CHK(st, SWPS_DORMANT)
        tick <= 1'b1;
        wait_st(SWPS_RAMP1, c);
        repeat (2) @(posedge clk);
        `CHK(outs, 7'b1001010)
        wait_st(SWPS_RAMP2, c);
        `CHK(c >= 8, 1'b1)
        repeat (2) @(posedge clk);
        `CHK(outs, 7'b1111100)
        wait_st(SWPS_RUNNING, c);
        `CHK(c >= 8, 1'b1)
    endtask : walk
    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // ========================================================================
    // Clock, watchdog and test sequence
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200_000;
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
        wr(SWPS_OFS_RAMP1_SET, 32'hffff_ffff);
        rd(SWPS_OFS_RAMP1_SET, 32'h001f_4331);
        wr(SWPS_OFS_GEN_CTRL, 32'hffff_fffd);
        rd(SWPS_OFS_GEN_CTRL, 32'h0000_003c);
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18, 32'h0);
        wr(SWPS_OFS_WAKE_LOW, 32'h0000_1000);
        wr(SWPS_OFS_WAKE_HIGH, 32'h0000_0006);
        rd(SWPS_OFS_WAKE_HIGH, 32'h0000_0006);
        wr(SWPS_OFS_DORMANT_SET, 32'h0002_4320);
        wr(SWPS_OFS_RAMP1_SET, 32'h0000_0221);
        wr(SWPS_OFS_RAMP2_SET, 32'h0000_0131);
        rd(SWPS_OFS_RAMP2_SET, 32'h0000_0133);
        walk(32'h0c, 1'b1, rtc);
        walk(32'h04, 1'b0, rtc);
        rtc <= 64'h5_0000_0fff;
        walk(32'h10, 1'b0, 64'h0_0000_1000);
        walk(32'h30, 1'b0, 64'h7_0000_0000);
        {lag, pin} <= {4'h0, 1'b1};
        wr(SWPS_OFS_DORMANT_SET, 32'h0003_4320);
        wr(SWPS_OFS_GEN_CTRL, 32'h0e);
        wait_st(SWPS_DORMANT, c);
        wait_st(SWPS_RAMP1, c);
        `CHK(c, 8)
        wait_st(SWPS_RUNNING, c);
        tally_and_finish();
    end
endmodule : tb_swps_top
`default_nettype wire
